// ==== rtl/rie_regs.svh ====
// Purpose: constants for the return instruction executor
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes: opcodes follow the core's instruction encoding
`ifndef RIE_REGS_SVH
`define RIE_REGS_SVH

`define RIE_OP_RETURN 14'h0008
`define RIE_OP_RETFI 14'h0009
`define RIE_OP_RETLIT_MASK 14'h3C00
`define RIE_OP_RETLIT_MATCH 14'h3400
`define RIE_INT_ENABLE_BIT 3'h7
`define RIE_RET_CYCLES 2'h2
`define RIE_NOP_WORD 14'h0000
`define RIE_PC_RESET 13'h0000
`define RIE_W_RESET 8'h00
`define RIE_INTCTL_RESET 8'h00

`endif

// ==== rtl/rie_pkg.sv ====
// Purpose: types for the return instruction executor
// Assumes: nothing beyond the constants header
// Notes: kind of return in flight
package rie_pkg;
    typedef logic [13:0] rie_word_t;
    typedef logic [12:0] rie_pc_t;
    typedef enum logic [1:0] {
        RIE_KIND_NONE = 2'b00,
        RIE_KIND_SUB = 2'b01,
        RIE_KIND_LIT = 2'b10,
        RIE_KIND_INT = 2'b11
    } rie_kind_e;
endpackage

// ==== rtl/rie_decode.sv ====
// Purpose: classifies a fetched word as a return kind
// Assumes: word is the instruction about to execute
// Notes: purely combinational
`timescale 1ns/1ps
`include "rie_regs.svh"
module rie_decode (
    input wire rie_pkg::rie_word_t instr,
    output rie_pkg::rie_kind_e kind
);
    import rie_pkg::*;

    always_comb begin
        if (instr == `RIE_OP_RETURN) begin
            kind = RIE_KIND_SUB;
        end else if (instr == `RIE_OP_RETFI) begin
            kind = RIE_KIND_INT;
        end else if ((instr & `RIE_OP_RETLIT_MASK) == `RIE_OP_RETLIT_MATCH) begin
            kind = RIE_KIND_LIT;
        end else begin
            kind = RIE_KIND_NONE;
        end
    end
endmodule

// ==== rtl/rie_exec.sv ====
// Purpose: executes the three return instructions of the core
// Assumes: one clk edge per instruction cycle while clk_en is high
// Notes: stack storage lives outside; this block only pops it
`timescale 1ns/1ps
`include "rie_regs.svh"

// Behaviour
// - interrupt return pops stack into pc
// - interrupt return sets global interrupt enable
// - interrupt return: two cycles, flags unchanged
// - literal return writes operand into accumulator
// - literal return loads pc from stack
// - literal return takes two cycles
// - subroutine return pops stack into pc
// - subroutine return takes two cycles
module rie_exec (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire rie_pkg::rie_word_t instr,
    input wire logic instr_valid,
    input wire rie_pkg::rie_pc_t stack_top,
    input wire logic [7:0] status_in,
    output logic stack_pop,
    output rie_pkg::rie_pc_t pc_reg,
    output logic pc_load,
    output logic [7:0] w_reg,
    output logic [7:0] interrupt_control_reg,
    output logic global_interrupt_enable,
    output logic [7:0] status_out,
    output logic flush_prefetch,
    output logic busy,
    output rie_pkg::rie_word_t exec_word
);
    import rie_pkg::*;

    // ==========================================
    // decode and sequencing
    rie_kind_e kind;
    rie_kind_e kind_reg;
    logic second_reg;
    logic start;

    rie_decode rie_decode_i (
        .instr(instr),
        .kind(kind)
    );

    // a new return is only taken outside the flush cycle
    assign start = clk_en && instr_valid && !second_reg && (kind != RIE_KIND_NONE);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            second_reg <= 1'b0;
            kind_reg <= RIE_KIND_NONE;
        end else if (clk_en) begin
            second_reg <= start;
            kind_reg <= start ? kind : RIE_KIND_NONE;
        end
    end

    assign stack_pop = start;
    assign pc_load = start;
    assign busy = start || second_reg;
    assign flush_prefetch = second_reg;
    // prefetched word replaced by a nop in the second cycle
    assign exec_word = second_reg ? `RIE_NOP_WORD : instr;
    // status passes straight through: returns touch no flag
    assign status_out = status_in;

    // ==========================================
    // program counter
    // stand-in for fetch: one step per plain valid word, wraps at the top
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_reg <= `RIE_PC_RESET;
        end else if (clk_en) begin
            if (start) begin
                pc_reg <= stack_top;
            end else if (!second_reg && instr_valid) begin
                pc_reg <= pc_reg + 13'h0001;
            end
        end
    end

    // ==========================================
    // accumulator
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            w_reg <= `RIE_W_RESET;
        end else if (clk_en && start && kind == RIE_KIND_LIT) begin
            w_reg <= instr[7:0];
        end
    end

    // ==========================================
    // interrupt control
    // apart from reset, only ever sets the enable; clearing it otherwise belongs to interrupt entry
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_control_reg <= `RIE_INTCTL_RESET;
        end else if (clk_en && start && kind == RIE_KIND_INT) begin
            interrupt_control_reg[`RIE_INT_ENABLE_BIT] <= 1'b1;
        end
    end
    assign global_interrupt_enable = interrupt_control_reg[`RIE_INT_ENABLE_BIT];

    // ==========================================
    // checks
    sequence s_ret_taken;
        clk_en && start;
    endsequence

    sequence s_flush_cycle;
        second_reg && flush_prefetch && exec_word == `RIE_NOP_WORD;
    endsequence

    chk_intret_pc_load: assert property (@(posedge clk) disable iff (!reset_n)
        s_ret_taken and kind == RIE_KIND_INT |=> pc_reg == $past(stack_top))
        else $error("pc not loaded from stack on interrupt return");

    chk_intret_gie_set: assert property (@(posedge clk) disable iff (!reset_n)
        s_ret_taken and kind == RIE_KIND_INT |=> global_interrupt_enable)
        else $error("interrupt enable not set");

    chk_intret_two_cycles: assert property (@(posedge clk) disable iff (!reset_n)
        s_ret_taken and kind == RIE_KIND_INT |=> s_flush_cycle
            ##1 (!second_reg || !$past(clk_en)))
        else $error("interrupt return not two cycles");

    chk_status_kept: assert property (@(posedge clk) disable iff (!reset_n)
        busy |-> status_out == status_in)
        else $error("status changed by return");

    chk_lit_to_w: assert property (@(posedge clk) disable iff (!reset_n)
        s_ret_taken and kind == RIE_KIND_LIT |=> w_reg == $past(instr[7:0]))
        else $error("literal not written to accumulator");

    chk_lit_pc_load: assert property (@(posedge clk) disable iff (!reset_n)
        s_ret_taken and kind == RIE_KIND_LIT |-> stack_pop ##1 pc_reg == $past(stack_top))
        else $error("pc not loaded on literal return");

    chk_lit_two_cycles: assert property (@(posedge clk) disable iff (!reset_n)
        s_ret_taken and kind == RIE_KIND_LIT |=> s_flush_cycle)
        else $error("literal return not two cycles");

    chk_sub_pc_load: assert property (@(posedge clk) disable iff (!reset_n)
        s_ret_taken and kind == RIE_KIND_SUB |=> pc_reg == $past(stack_top) && !stack_pop)
        else $error("pc not loaded on subroutine return");

    chk_sub_two_cycles: assert property (@(posedge clk) disable iff (!reset_n)
        s_ret_taken and kind == RIE_KIND_SUB |=> s_flush_cycle)
        else $error("subroutine return not two cycles");

    chk_flush_pc_hold: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && second_reg |=> $stable(pc_reg) && !second_reg)
        else $error("flush cycle moved pc or repeated");

    // ==========================================
    // stall, ordering and decode checks
    // clk_en low has to look exactly like a missing clock edge
    sequence s_stalled;
        !clk_en;
    endsequence

    chk_stall_no_pop: assert property (@(posedge clk) disable iff (!reset_n)
        s_stalled
        |-> !stack_pop && !pc_load)
        else $error("return taken while stalled");

    chk_stall_freeze: assert property (@(posedge clk) disable iff (!reset_n)
        s_stalled
        |=> $stable(pc_reg) && $stable(w_reg) && $stable(second_reg))
        else $error("state moved while stalled");

    chk_stall_intctl: assert property (@(posedge clk) disable iff (!reset_n)
        s_stalled
        |=> $stable(interrupt_control_reg))
        else $error("interrupt control moved while stalled");

    chk_take_strobes: assert property (@(posedge clk) disable iff (!reset_n)
        start
        |-> stack_pop && pc_load && busy)
        else $error("take cycle strobes missing");

    chk_flush_refuse: assert property (@(posedge clk) disable iff (!reset_n)
        second_reg
        |-> !stack_pop && !pc_load)
        else $error("return accepted in flush cycle");

    chk_flush_kind: assert property (@(posedge clk) disable iff (!reset_n)
        second_reg
        |-> kind_reg != RIE_KIND_NONE)
        else $error("flush cycle without a return in flight");

    chk_exec_passthru: assert property (@(posedge clk) disable iff (!reset_n)
        !second_reg
        |-> exec_word == instr)
        else $error("executed word altered outside flush");

    chk_gie_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        global_interrupt_enable
        |=> global_interrupt_enable)
        else $error("interrupt enable cleared");

    chk_gie_cause: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(global_interrupt_enable)
        |-> kind_reg == RIE_KIND_INT)
        else $error("interrupt enable set without interrupt return");

    chk_intctl_others: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1
        |-> interrupt_control_reg[6:0] == 7'h00)
        else $error("interrupt control low bits written");

    chk_w_cause: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(w_reg)
        |-> kind_reg == RIE_KIND_LIT)
        else $error("accumulator written without literal return");

    chk_second_cause: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(second_reg)
        |-> $past(stack_pop))
        else $error("flush cycle without a pop");

    chk_busy_idle: assert property (@(posedge clk) disable iff (!reset_n)
        !instr_valid && !second_reg
        |-> !busy)
        else $error("busy with nothing in flight");
endmodule

// ==== test/tb_return_instruction_exec.sv ====
// Purpose: self-checking bench for the return instruction executor
// Assumes: inputs driven 1 ns after each rising edge
// Notes: each return is followed by a refused return in its flush cycle
`timescale 1ns/1ps
`include "rie_regs.svh"
module tb_return_instruction_exec;
    import rie_pkg::*;
    logic clk, reset_n, clk_en, instr_valid, stack_pop, pc_load, global_interrupt_enable;
    logic flush_prefetch, busy;
    rie_word_t instr, exec_word;
    rie_pc_t stack_top, pc_reg;
    logic [7:0] status_in, w_reg, interrupt_control_reg, status_out;
    int miscompares, n_checks;
    rie_exec rie_exec_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .instr(instr),
        .instr_valid(instr_valid), .stack_top(stack_top), .status_in(status_in),
        .stack_pop(stack_pop), .pc_reg(pc_reg), .pc_load(pc_load), .w_reg(w_reg),
        .interrupt_control_reg(interrupt_control_reg),
        .global_interrupt_enable(global_interrupt_enable), .status_out(status_out),
        .flush_prefetch(flush_prefetch), .busy(busy), .exec_word(exec_word));
    // ==========================================
    // compare and closing
    task automatic chk_val(input logic [13:0] got, input logic [13:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({13'h0000, got}, {13'h0000, exp});
    endtask
    task automatic chk_cleared;
        chk_val({1'b0, pc_reg}, {1'b0, `RIE_PC_RESET});
        chk_val({6'h00, w_reg}, {6'h00, `RIE_W_RESET});
        chk_val({6'h00, interrupt_control_reg}, {6'h00, `RIE_INTCTL_RESET});
        chk_bit(global_interrupt_enable | flush_prefetch | busy, 1'b0);
    endtask
    task automatic wrap_up;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========================================
    // one return, then a return offered in the flush cycle must be ignored
    task automatic do_ret(input rie_word_t op, input rie_pc_t top, input logic [7:0] w_exp,
                          input logic ie_exp);
        @(posedge clk);
        #1 instr = op;
        instr_valid = 1'b1;
        stack_top = top;
        status_in = ~top[7:0];
        #1 chk_bit(stack_pop, 1'b1);
        chk_bit(pc_load & busy, 1'b1);
        chk_val({6'h00, status_out}, {6'h00, status_in});
        @(posedge clk);
        #1 stack_top = ~top;
        #1 chk_val({1'b0, pc_reg}, {1'b0, top});
        chk_val({6'h00, w_reg}, {6'h00, w_exp});
        chk_val({6'h00, interrupt_control_reg}, {6'h00, ie_exp, 7'h00});
        chk_bit(global_interrupt_enable, ie_exp);
        chk_bit(flush_prefetch & busy, 1'b1);
        chk_bit(stack_pop, 1'b0);
        chk_val(exec_word, `RIE_NOP_WORD);
        @(posedge clk);
        #1 instr_valid = 1'b0;
        #1 chk_val({1'b0, pc_reg}, {1'b0, top});
        chk_bit(flush_prefetch | busy, 1'b0);
    endtask
    task automatic test_sub;
        do_ret(`RIE_OP_RETURN, 13'h1ABC, 8'h00, 1'b0);
        $display("test_sub done");
    endtask
    task automatic test_lit;
        do_ret(14'h34FF, 13'h0001, 8'hFF, 1'b0);
        do_ret(14'h3700, 13'h1FFF, 8'h00, 1'b0);
        $display("test_lit done");
    endtask
    task automatic test_int;
        do_ret(`RIE_OP_RETFI, 13'h0555, 8'h00, 1'b1);
        do_ret(14'h355A, 13'h0AAA, 8'h5A, 1'b1);
        $display("test_int done");
    endtask
    // plain words only fetch: pc steps by one, wraps, holds when idle
    task automatic test_fetch;
        do_ret(`RIE_OP_RETURN, 13'h1FFE, 8'h5A, 1'b1);
        @(posedge clk);
        #1 instr = 14'h3800;
        instr_valid = 1'b1;
        #1 chk_bit(stack_pop | busy, 1'b0);
        chk_val(exec_word, 14'h3800);
        @(posedge clk);
        #1 instr = 14'h000A;
        #1 chk_val({1'b0, pc_reg}, 14'h1FFF);
        chk_bit(stack_pop | busy, 1'b0);
        @(posedge clk);
        #1 instr_valid = 1'b0;
        #1 chk_val({1'b0, pc_reg}, 14'h0000);
        chk_val({6'h00, w_reg}, 14'h005A);
        @(posedge clk);
        #2 chk_val({1'b0, pc_reg}, 14'h0000);
        $display("test_fetch done");
    endtask
    // clk_en low in the take cycle and in the flush cycle stretches both
    task automatic test_stall;
        @(posedge clk);
        #1 instr = `RIE_OP_RETFI;
        instr_valid = 1'b1;
        stack_top = 13'h0F0F;
        clk_en = 1'b0;
        #1 chk_bit(stack_pop | busy, 1'b0);
        @(posedge clk);
        #1 clk_en = 1'b1;
        #1 chk_val({1'b0, pc_reg}, 14'h0000);
        chk_bit(stack_pop, 1'b1);
        @(posedge clk);
        #1 clk_en = 1'b0;
        #1 chk_val({1'b0, pc_reg}, 14'h0F0F);
        @(posedge clk);
        #1 clk_en = 1'b1;
        #1 chk_bit(flush_prefetch & busy, 1'b1);
        chk_bit(stack_pop, 1'b0);
        chk_val({1'b0, pc_reg}, 14'h0F0F);
        @(posedge clk);
        #1 instr_valid = 1'b0;
        #1 chk_bit(flush_prefetch | busy, 1'b0);
        chk_val({1'b0, pc_reg}, 14'h0F0F);
        $display("test_stall done");
    endtask
    // reset in mid-run clears enable and accumulator; returns work right after
    task automatic test_reset;
        @(posedge clk);
        #1 reset_n = 1'b0;
        #1 chk_cleared();
        @(posedge clk);
        #1 reset_n = 1'b1;
        do_ret(14'h3481, 13'h0042, 8'h81, 1'b0);
        $display("test_reset done");
    endtask
    // ==========================================
    // clock, reset, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        instr = `RIE_NOP_WORD;
        instr_valid = 1'b0;
        stack_top = 13'h0000;
        status_in = 8'h00;
        repeat (3) @(posedge clk);
        #1 chk_cleared();
        reset_n = 1'b1;
        test_sub();
        test_lit();
        test_int();
        test_fetch();
        test_stall();
        test_reset();
        wrap_up();
    end
    initial begin
        #5000;
        miscompares++;
        wrap_up();
    end
endmodule
